/* File: include/sbmhp_pkg.sv */
// Shared constants and types for the strobe bus mode host port
package sbmhp_pkg;
	// Register offsets (word addresses on the 16-bit bus)
	localparam logic [15:0] SBMHP_OFS_BUS_CFG  = 16'h0000;
	localparam logic [15:0] SBMHP_OFS_BASE_ROM = 16'h0002;
	localparam logic [15:0] SBMHP_OFS_CARD_OPT = 16'h8000;
	localparam logic [15:0] SBMHP_OFS_CARD_STS = 16'h8002;
	// Field positions in bus_configuration
	localparam int SBMHP_BIT_IRQ_SEL_LO = 1;
	localparam int SBMHP_BIT_IRQ_SEL_HI = 2;
	localparam int SBMHP_BIT_WIDE_BUS   = 7;
	localparam int SBMHP_BIT_NO_WAIT    = 12;
	// Field positions in base_address_and_rom_size
	localparam int SBMHP_BIT_ROM_SIZE_LO = 6;
	localparam int SBMHP_BIT_ROM_SIZE_HI = 7;
	// Reset values
	localparam logic [15:0] SBMHP_RST_BUS_CFG  = 16'h0000;
	localparam logic [15:0] SBMHP_RST_BASE_ROM = 16'h0000;
	localparam logic [15:0] SBMHP_RST_CARD_OPT = 16'h0000;
	localparam logic [15:0] SBMHP_RST_CARD_STS = 16'h0000;
	// Wait request length: two to three 20 MHz clocks, short end of 100 ns taken
	localparam int SBMHP_WAIT_NS     = 100;
	localparam int SBMHP_CLK_NS      = 4;
	localparam int SBMHP_WAIT_CYCLES = SBMHP_WAIT_NS / SBMHP_CLK_NS;
	// Bus mode of the device port
	typedef enum logic [1:0] {
		SBMHP_MODE_ISA    = 2'b00,
		SBMHP_MODE_VERIFY = 2'b01,
		SBMHP_MODE_STROBE = 2'b11,
		SBMHP_MODE_CARD   = 2'b10
	} sbmhp_mode_type;
	// Host sequencer states
	typedef enum logic [2:0] {
		SBMHP_H_IDLE  = 3'b000,
		SBMHP_H_ENTRY = 3'b001,
		SBMHP_H_GAP   = 3'b011,
		SBMHP_H_SETUP = 3'b010,
		SBMHP_H_STRB  = 3'b110,
		SBMHP_H_DONE  = 3'b111
	} sbmhp_hstate_type;
endpackage

/* File: include/sbmhp_if.sv */
// Pin level carrier between the host processor end and the device end
`timescale 1ns/1ps
interface sbmhp_if;
	logic        rd_n;        // ISA read strobe, low active
	logic        wr_n;        // ISA write strobe / strobe mode direction
	logic        ds_n;        // Data strobe, low active
	logic [15:0] addr;        // Word address
	logic [15:0] d_host;      // Host data out
	logic        d_host_oe;   // Host drives data
	logic [15:0] d_dev;       // Device data out
	logic        d_dev_oe;    // Device drives data
	logic        ack_a_n_o;   // Transfer acknowledge A level
	logic        ack_a_oe;    // Transfer acknowledge A enable
	logic        ack_b_n_o;   // Transfer acknowledge B level
	logic        ack_b_oe;    // Transfer acknowledge B enable
	logic        ready;       // ISA ready, high when no wait
	modport host (output rd_n, wr_n, ds_n, addr, d_host, d_host_oe,
		input d_dev, d_dev_oe, ack_a_n_o, ack_a_oe, ack_b_n_o, ack_b_oe, ready);
	modport device (input rd_n, wr_n, ds_n, addr, d_host, d_host_oe,
		output d_dev, d_dev_oe, ack_a_n_o, ack_a_oe, ack_b_n_o, ack_b_oe, ready);
endinterface

/* File: verilog/sbmhp_device.sv */
// Device end: bus mode selection, configuration registers and strobe cycles
//
// How it works
// - Sample straps at reset release, ISA sixteen
// - Rom select low means card mode
// - Both strobes low switch to strobe mode
// - First strobe access must be write
// - Strobe mode held until hard reset
// - Reset clears the selected bus mode
// - Unselected acknowledge pins stay tri-stated
// - Host leaves card registers untouched
// - Wide bit reads inverse of width pin
// - Host always writes wide bit one
// - No-wait clear drops ready each ISA access
// - Two bits pick interrupt pin, zero
// - Bytes pass through without swapping
// - Rom size zero disables rom decode
// - Read drives register data on bus
// - Write captures bus into register
// - Acknowledge pins never go low
// - No wait states in strobe mode, host never waits
// - All registers reachable in strobe mode
`timescale 1ns/1ps
module sbmhp_device
	import sbmhp_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// Carrier
	sbmhp_if.device          BUS,
	// Strap pins
	input  wire logic        WIDTH_SELECT_N_I,
	input  wire logic        ROM_SELECT_N_I,
	// Status and pins toward the user side
	output logic             ROM_SELECT_N_O,
	output logic             ROM_SELECT_OE_O,
	output logic [1:0]       MODE_O,
	output logic             IRQ_OUT_ZERO_O,
	output logic             PROTO_ERR_O,
	// Internal interrupt request to route
	input  wire logic        IRQ_REQ_I,
	// Rom decode address lines
	input  wire logic [3:0]  ROM_ADDR_HI_I
);
	// Whole device state
	typedef struct packed {
		sbmhp_mode_type mode;       // Current bus mode
		logic           in_reset;   // Reset seen, release sampling due
		logic           strobes;    // Previous cycle had an access strobe
		logic [15:0]    bus_cfg;    // bus_configuration
		logic [15:0]    base_rom;   // base_address_and_rom_size
		logic [15:0]    card_opt;   // card_configuration_option
		logic [15:0]    card_sts;   // card_configuration_status
		logic [15:0]    rd_data;    // Read data driven out
		logic           rd_oe;      // Read data enable
		logic [7:0]     wait_cnt;   // Ready low counter
		logic           ready;      // ISA ready
		logic           ack_a_oe;   // Acknowledge A enable
		logic           ack_b_oe;   // Acknowledge B enable
		logic           irq0;       // Interrupt output zero
		logic           rom_n;      // Rom select level
		logic           rom_oe;     // Rom select enable
		logic           err;        // Sticky protocol error
	} sbmhp_dev_type;

	sbmhp_dev_type s_q;
	sbmhp_dev_type s_d;
	logic          strobe_cyc;  // Strobe mode access active
	logic          isa_rd;      // ISA read active
	logic          isa_wr;      // ISA write active
	logic          access;      // Any access active
	logic          is_write;    // Access is a write
	logic [15:0]   rd_mux;      // Addressed register contents
	logic [1:0]    irq_sel;     // Interrupt pin selection

	// Cycle decoding is qualified by the mode flag
	always_comb begin
		// Card mode must not decode the data strobe, so name both strobe modes
		strobe_cyc = (s_q.mode == SBMHP_MODE_VERIFY || s_q.mode == SBMHP_MODE_STROBE) && !BUS.ds_n;
		isa_rd     = (s_q.mode == SBMHP_MODE_ISA) && !BUS.rd_n && BUS.wr_n;
		isa_wr     = (s_q.mode == SBMHP_MODE_ISA) && BUS.rd_n && !BUS.wr_n;
		access     = strobe_cyc || isa_rd || isa_wr;
		is_write   = strobe_cyc ? !BUS.wr_n : isa_wr;
		irq_sel    = {s_q.bus_cfg[SBMHP_BIT_IRQ_SEL_HI], s_q.bus_cfg[SBMHP_BIT_IRQ_SEL_LO]};
	end

	// Register read multiplexer, same map in every mode
	always_comb begin
		case (BUS.addr)
			SBMHP_OFS_BUS_CFG:  rd_mux = s_q.bus_cfg;
			SBMHP_OFS_BASE_ROM: rd_mux = s_q.base_rom;
			SBMHP_OFS_CARD_OPT: rd_mux = s_q.card_opt;
			SBMHP_OFS_CARD_STS: rd_mux = s_q.card_sts;
			default:            rd_mux = 16'h0000;
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.strobes = access;
		if (RST_I) begin
			// Mode forgotten; straps taken at release
			s_d.mode     = SBMHP_MODE_ISA;
			s_d.in_reset = 1'b1;
			s_d.bus_cfg  = SBMHP_RST_BUS_CFG;
			s_d.base_rom = SBMHP_RST_BASE_ROM;
			s_d.card_opt = SBMHP_RST_CARD_OPT;
			s_d.card_sts = SBMHP_RST_CARD_STS;
			s_d.rd_oe    = 1'b0;
			s_d.ready    = 1'b1;
			s_d.wait_cnt = 8'h00;
			s_d.err      = 1'b0;
			s_d.strobes  = 1'b0;
		end else if (s_q.in_reset) begin
			// First cycle after release: straps sampled
			s_d.in_reset = 1'b0;
			s_d.bus_cfg[SBMHP_BIT_WIDE_BUS] = !WIDTH_SELECT_N_I;
			if (!ROM_SELECT_N_I) begin
				s_d.mode = SBMHP_MODE_CARD;
			end else begin
				s_d.mode = SBMHP_MODE_ISA;
			end
		end else begin
			// Entry: both ISA strobes low together, only from ISA
			if (s_q.mode == SBMHP_MODE_ISA && !BUS.rd_n && !BUS.wr_n) begin
				s_d.mode = SBMHP_MODE_VERIFY;
			end
			// First strobe access after entry confirms the mode
			if (s_q.mode == SBMHP_MODE_VERIFY && strobe_cyc && !s_q.strobes) begin
				s_d.mode = SBMHP_MODE_STROBE;
				if (BUS.wr_n) begin
					s_d.err = 1'b1;
				end
			end
			// No path leads out of strobe mode but reset
			// Read data from the addressed register, bytes unswapped
			s_d.rd_oe   = access && !is_write && s_q.mode != SBMHP_MODE_VERIFY;
			s_d.rd_data = rd_mux;
			// Write capture on the first cycle of the access
			if (access && is_write && !s_q.strobes) begin
				case (BUS.addr)
					SBMHP_OFS_BUS_CFG:  s_d.bus_cfg  = BUS.d_host;
					SBMHP_OFS_BASE_ROM: s_d.base_rom = BUS.d_host;
					SBMHP_OFS_CARD_OPT: s_d.card_opt = BUS.d_host;
					SBMHP_OFS_CARD_STS: s_d.card_sts = BUS.d_host;
					default:            s_d.err      = s_q.err;
				endcase
			end
			// Wait request on every ISA access unless suppressed
			if ((isa_rd || isa_wr) && !s_q.strobes && !s_q.bus_cfg[SBMHP_BIT_NO_WAIT]) begin
				s_d.ready    = 1'b0;
				s_d.wait_cnt = 8'(SBMHP_WAIT_CYCLES - 1);
			end else if (s_q.wait_cnt != 8'h00) begin
				s_d.wait_cnt = s_q.wait_cnt - 8'h01;
			end else begin
				s_d.ready = 1'b1;
			end
		end
		// Acknowledge pins: enabled only when chosen, then held high
		s_d.ack_a_oe = (irq_sel == 2'b00);
		s_d.ack_b_oe = (irq_sel == 2'b01);
		s_d.irq0     = IRQ_REQ_I && (irq_sel == 2'b00);
		// Rom decode off when size is zero; otherwise pin low when ROM_ADDR_HI_I is all ones
		s_d.rom_oe = (s_q.mode == SBMHP_MODE_ISA) && !s_q.in_reset;
		if (s_q.base_rom[SBMHP_BIT_ROM_SIZE_HI:SBMHP_BIT_ROM_SIZE_LO] == 2'b00) begin
			s_d.rom_n = 1'b1;
		end else begin
			s_d.rom_n = !(ROM_ADDR_HI_I == 4'hf);
		end
	end

	// State register, synchronous reset folded into the next state
	always_ff @(posedge CLK_I) begin
		s_q <= s_d;
	end

	// Pin outputs straight from flip-flops; device needs no wait in strobe mode
	assign BUS.d_dev     = s_q.rd_data;
	assign BUS.d_dev_oe  = s_q.rd_oe;
	assign BUS.ack_a_n_o = 1'b1;
	assign BUS.ack_a_oe  = s_q.ack_a_oe;
	assign BUS.ack_b_n_o = 1'b1;
	assign BUS.ack_b_oe  = s_q.ack_b_oe;
	assign BUS.ready     = s_q.ready;
	assign ROM_SELECT_N_O  = s_q.rom_n;
	assign ROM_SELECT_OE_O = s_q.rom_oe;
	assign MODE_O          = s_q.mode;
	assign IRQ_OUT_ZERO_O  = s_q.irq0;
	assign PROTO_ERR_O     = s_q.err;
endmodule // sbmhp_device

/* File: verilog/sbmhp_host.sv */
// Host end: entry sequence and strobe mode register cycles
`timescale 1ns/1ps
module sbmhp_host
	import sbmhp_pkg::*;
#(
	parameter int STROBE_CYCLES = 4  // Data strobe low time in clocks
)(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// Carrier
	sbmhp_if.host            BUS,
	// User command port
	input  wire logic        ENTER_I,   // Start the entry sequence
	input  wire logic        REQ_I,     // Register access request
	input  wire logic        WRITE_I,   // Access is a write
	input  wire logic [15:0] ADDR_I,    // Register address
	input  wire logic [15:0] WDATA_I,   // Write data
	output logic             READY_O,   // Accepts a request
	output logic             DONE_O,    // Access finished, one cycle
	output logic [15:0]      RDATA_O,   // Read data
	output logic             ENTERED_O  // Strobe mode entered
);
	// Whole host state
	typedef struct packed {
		sbmhp_hstate_type st;
		logic [7:0]  cnt;
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        done;
		logic        entered;
		logic        rd_n;
		logic        wr_n;
		logic        ds_n;
		logic        oe;
		logic        rdy;
	} sbmhp_host_type;

	sbmhp_host_type h_q;
	sbmhp_host_type h_d;

	// Sequencer
	always_comb begin
		h_d      = h_q;
		h_d.done = 1'b0;
		case (h_q.st)
			SBMHP_H_IDLE: begin
				if (ENTER_I && !h_q.entered) begin
					// Both ISA strobes low together
					h_d.rd_n = 1'b0;
					h_d.wr_n = 1'b0;
					h_d.st   = SBMHP_H_ENTRY;
				end else if (REQ_I && h_q.entered) begin
					h_d.write = WRITE_I;
					h_d.addr  = ADDR_I;
					// Wide bit forced one, interrupt select forced zero
					h_d.wdata = WDATA_I;
					if (ADDR_I == SBMHP_OFS_BUS_CFG) begin
						h_d.wdata[SBMHP_BIT_WIDE_BUS]   = 1'b1;
						h_d.wdata[SBMHP_BIT_IRQ_SEL_HI] = 1'b0;
						h_d.wdata[SBMHP_BIT_IRQ_SEL_LO] = 1'b0;
					end
					if (ADDR_I == SBMHP_OFS_BASE_ROM) begin
						h_d.wdata[SBMHP_BIT_ROM_SIZE_HI:SBMHP_BIT_ROM_SIZE_LO] = 2'b00;
					end
					// Card registers are never written
					if (WRITE_I && (ADDR_I == SBMHP_OFS_CARD_OPT || ADDR_I == SBMHP_OFS_CARD_STS)) begin
						h_d.done = 1'b1;
					end else begin
						h_d.st = SBMHP_H_SETUP;
					end
				end
			end
			SBMHP_H_ENTRY: begin
				h_d.rd_n = 1'b1;
				h_d.wr_n = 1'b1;
				h_d.st   = SBMHP_H_GAP;
			end
			SBMHP_H_GAP: begin
				// Confirming write to the configuration register
				h_d.write   = 1'b1;
				h_d.addr    = SBMHP_OFS_BUS_CFG;
				h_d.wdata   = 16'h0000;
				h_d.wdata[SBMHP_BIT_WIDE_BUS] = 1'b1;
				h_d.entered = 1'b1;
				h_d.st      = SBMHP_H_SETUP;
			end
			SBMHP_H_SETUP: begin
				h_d.wr_n = !h_q.write;
				h_d.oe   = h_q.write;
				h_d.ds_n = 1'b0;
				h_d.cnt  = 8'(STROBE_CYCLES - 1);
				h_d.st   = SBMHP_H_STRB;
			end
			SBMHP_H_STRB: begin
				// Fixed length, no acknowledge awaited
				if (h_q.cnt != 8'h00) begin
					h_d.cnt = h_q.cnt - 8'h01;
				end else begin
					h_d.rdata = BUS.d_dev;
					h_d.ds_n  = 1'b1;
					h_d.st    = SBMHP_H_DONE;
				end
			end
			SBMHP_H_DONE: begin
				h_d.wr_n = 1'b1;
				h_d.oe   = 1'b0;
				h_d.done = 1'b1;
				h_d.st   = SBMHP_H_IDLE;
			end
			default: h_d.st = SBMHP_H_IDLE;
		endcase
		if (RST_I) begin
			h_d         = '0;
			h_d.st      = SBMHP_H_IDLE;
			h_d.rd_n    = 1'b1;
			h_d.wr_n    = 1'b1;
			h_d.ds_n    = 1'b1;
		end
		// Ready registered from the next state, so it is a flip-flop output
		h_d.rdy = (h_d.st == SBMHP_H_IDLE) && !RST_I;
	end

	// State register
	always_ff @(posedge CLK_I) begin
		h_q <= h_d;
	end

	// Outputs from flip-flops
	assign BUS.rd_n      = h_q.rd_n;
	assign BUS.wr_n      = h_q.wr_n;
	assign BUS.ds_n      = h_q.ds_n;
	assign BUS.addr      = h_q.addr;
	assign BUS.d_host    = h_q.wdata;
	assign BUS.d_host_oe = h_q.oe;
	assign READY_O       = h_q.rdy;
	assign DONE_O        = h_q.done;
	assign RDATA_O       = h_q.rdata;
	assign ENTERED_O     = h_q.entered;
endmodule // sbmhp_host

/* File: dv/sbmhp_assertions.sv */
// Interface rule checker for the strobe bus mode host port
`timescale 1ns/1ps
module sbmhp_assertions (
	// Clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_I,
	// Strobes and address
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        ds_n,
	input wire logic [15:0] addr,
	// Data lanes
	input wire logic [15:0] d_host,
	input wire logic        d_host_oe,
	input wire logic [15:0] d_dev,
	input wire logic        d_dev_oe,
	// Acknowledge pins and ready
	input wire logic        ack_a_n_o,
	input wire logic        ack_a_oe,
	input wire logic        ack_b_n_o,
	input wire logic        ack_b_oe,
	input wire logic        ready
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// Both ISA strobes low together
	sequence s_entry;
		!rd_n && !wr_n;
	endsequence
	// Strobe write with host data on the bus
	sequence s_write;
		!ds_n && !wr_n && d_host_oe;
	endsequence
	// Strobe read
	sequence s_read;
		!ds_n && wr_n;
	endsequence
	a_ack_a_high: assert property (ack_a_oe |-> ack_a_n_o) else $error("ack a driven low");
	a_ack_b_high: assert property (ack_b_oe |-> ack_b_n_o) else $error("ack b driven low");
	a_ack_one_sel: assert property (!(ack_a_oe && ack_b_oe)) else $error("both ack pins on");
	a_entry_then_write: assert property (s_entry |=> ds_n ##[1:8] s_write) else $error("no confirm write");
	a_strobe_len: assert property ($fell(ds_n) |-> !ds_n[*4] ##1 ds_n) else $error("strobe length");
	a_strobe_hold: assert property ((!ds_n && $past(!ds_n)) |-> $stable(addr) && $stable(wr_n) && $stable(d_host))
		else $error("strobe not held");
	a_write_data_on: assert property ((!ds_n && !wr_n) |-> d_host_oe) else $error("write without data");
	a_read_answer: assert property (s_read |=> d_dev_oe) else $error("read not driven");
	a_dev_cause: assert property ($rose(d_dev_oe) |-> $past(!ds_n && wr_n)) else $error("device drove unasked");
	a_no_clash: assert property (!(d_host_oe && d_dev_oe)) else $error("data bus contention");
endmodule // sbmhp_assertions

/* File: dv/tb.sv */
// Self-checking bench joining host end and device end
`timescale 1ns/1ps
module tb
	import sbmhp_pkg::*;
();
	logic        clk = 1'b0;     // 250 MHz clock
	logic        rst = 1'b1;     // Sync reset
	logic        wsel_n = 1'b0;  // Width strap
	logic        rsel_n = 1'b1;  // Rom strap, floats high
	logic        irq_req = 1'b0; // Interrupt request
	logic        enter = 1'b0;   // Entry command
	logic        req = 1'b0;     // Access request
	logic        wr = 1'b0;      // Access is a write
	logic [15:0] adr = '0;       // Access address
	logic [15:0] wd = '0;        // Write data
	logic        rdy, done, entered, rom_n, rom_oe, irq0, perr;
	logic [15:0] rdat;           // Host read data
	logic [15:0] q;              // Last read value
	logic [1:0]  mode;           // Device bus mode
	int          err_total = 0;
	int          n_tests = 0;
	sbmhp_if sbmhp_if_i ();
	sbmhp_device sbmhp_device_i (.CLK_I(clk), .RST_I(rst), .BUS(sbmhp_if_i.device), .WIDTH_SELECT_N_I(wsel_n),
		.ROM_SELECT_N_I(rsel_n), .ROM_SELECT_N_O(rom_n), .ROM_SELECT_OE_O(rom_oe), .MODE_O(mode),
		.IRQ_OUT_ZERO_O(irq0), .PROTO_ERR_O(perr), .IRQ_REQ_I(irq_req), .ROM_ADDR_HI_I(4'hf));
	sbmhp_host #(.STROBE_CYCLES(4)) sbmhp_host_i (.CLK_I(clk), .RST_I(rst), .BUS(sbmhp_if_i.host),
		.ENTER_I(enter), .REQ_I(req), .WRITE_I(wr), .ADDR_I(adr), .WDATA_I(wd), .READY_O(rdy),
		.DONE_O(done), .RDATA_O(rdat), .ENTERED_O(entered));
	sbmhp_assertions sbmhp_assertions_i (.CLK_I(clk), .RST_I(rst), .rd_n(sbmhp_if_i.rd_n),
		.wr_n(sbmhp_if_i.wr_n), .ds_n(sbmhp_if_i.ds_n), .addr(sbmhp_if_i.addr), .d_host(sbmhp_if_i.d_host),
		.d_host_oe(sbmhp_if_i.d_host_oe), .d_dev(sbmhp_if_i.d_dev), .d_dev_oe(sbmhp_if_i.d_dev_oe),
		.ack_a_n_o(sbmhp_if_i.ack_a_n_o), .ack_a_oe(sbmhp_if_i.ack_a_oe), .ack_b_n_o(sbmhp_if_i.ack_b_n_o),
		.ack_b_oe(sbmhp_if_i.ack_b_oe), .ready(sbmhp_if_i.ready));
	// Free running clock
	always #2 clk = ~clk;
	// Compare and count
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Inputs move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Reset with given straps, then two edges before any request
	task automatic do_reset(input logic w_n, input logic r_n);
		rst = 1'b1;
		wsel_n = w_n;
		rsel_n = r_n;
		tick(4);
		rst = 1'b0;
		tick(2);
	endtask
	// Bounded wait for the host to idle
	task automatic wait_ready;
		for (int i = 0; i < 200 && rdy !== 1'b1; i++) tick(1);
		chk("host ready", 16'h0001, {15'h0000, rdy});
	endtask
	// Request held over the taking edge, then bounded wait for done
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
		wait_ready();
		req = 1'b1;
		wr = w;
		adr = a;
		wd = d;
		tick(1);
		req = 1'b0;
		for (int i = 0; i < 200 && done !== 1'b1; i++) tick(1);
		chk("access done", 16'h0001, {15'h0000, done});
		q = rdat;
	endtask
	// Entry sequence, bounded wait for the host to report it
	task automatic do_enter;
		wait_ready();
		enter = 1'b1;
		tick(1);
		enter = 1'b0;
		for (int i = 0; i < 200 && entered !== 1'b1; i++) tick(1);
		wait_ready();
	endtask
	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog, about eighty times the expected run
	initial begin
		#40000;
		err_total++;
		test_done();
	end
	// Main sequence
	initial begin
		do_reset(1'b0, 1'b1);
		irq_req = 1'b1;
		tick(2);
		chk("mode isa", {14'h0000, SBMHP_MODE_ISA}, {14'h0000, mode});
		chk("rom oe isa", 16'h0001, {15'h0000, rom_oe});
		chk("rom select idle", 16'h0001, {15'h0000, rom_n});
		chk("ack a enable", 16'h0001, {15'h0000, sbmhp_if_i.ack_a_oe});
		chk("ack b enable", 16'h0000, {15'h0000, sbmhp_if_i.ack_b_oe});
		chk("irq zero", 16'h0001, {15'h0000, irq0});
		chk("wide bit strap", 16'h0001, {15'h0000, sbmhp_device_i.s_q.bus_cfg[SBMHP_BIT_WIDE_BUS]});
		$display("test straps done");
		do_enter();
		chk("mode strobe", {14'h0000, SBMHP_MODE_STROBE}, {14'h0000, mode});
		chk("proto error", 16'h0000, {15'h0000, perr});
		access(1'b0, SBMHP_OFS_BUS_CFG, 16'h0000);
		chk("wide bit", 16'h0001, {15'h0000, q[SBMHP_BIT_WIDE_BUS]});
		chk("irq sel", 16'h0000, {14'h0000, q[2:1]});
		$display("test entry done");
		access(1'b1, SBMHP_OFS_BUS_CFG, 16'h5a3c);
		access(1'b0, SBMHP_OFS_BUS_CFG, 16'h0000);
		chk("bus cfg", 16'h5ab8, q);
		access(1'b1, SBMHP_OFS_BASE_ROM, 16'ha5ff);
		access(1'b0, SBMHP_OFS_BASE_ROM, 16'h0000);
		chk("base rom", 16'ha53f, q);
		for (int i = 0; i < 3; i++) begin
			adr = (i == 0) ? SBMHP_OFS_CARD_OPT : (i == 1) ? SBMHP_OFS_CARD_STS : 16'h0040;
			access(1'b1, adr, 16'hffff);
			access(1'b0, adr, 16'h0000);
			chk("reserved read", 16'h0000, q);
		end
		irq_req = 1'b0;
		tick(2);
		chk("irq zero off", 16'h0000, {15'h0000, irq0});
		chk("mode held", {14'h0000, SBMHP_MODE_STROBE}, {14'h0000, mode});
		chk("ready in strobe mode", 16'h0001, {15'h0000, sbmhp_if_i.ready});
		$display("test registers done");
		do_reset(1'b1, 1'b0);
		chk("mode card", {14'h0000, SBMHP_MODE_CARD}, {14'h0000, mode});
		chk("rom oe card", 16'h0000, {15'h0000, rom_oe});
		chk("wide bit strap high", 16'h0000, {15'h0000, sbmhp_device_i.s_q.bus_cfg[SBMHP_BIT_WIDE_BUS]});
		do_reset(1'b0, 1'b1);
		chk("mode isa again", {14'h0000, SBMHP_MODE_ISA}, {14'h0000, mode});
		do_enter();
		access(1'b1, SBMHP_OFS_BUS_CFG, 16'h1000);
		access(1'b0, SBMHP_OFS_BUS_CFG, 16'h0000);
		chk("cfg after reentry", 16'h1080, q);
		chk("mode reentered", {14'h0000, SBMHP_MODE_STROBE}, {14'h0000, mode});
		$display("test reset done");
		test_done();
	end
endmodule // tb
